// ---- shared/udsl_pkg.sv ----
// Operation
// R1 - Each status update writes the last transaction outcome into status bits 7:0.
// R2 - Software sets active bit 7 to let transactions run.
// R3 - Halted bit 6 set on babble, error counter reaching zero, or STALL.
// R4 - Any update that sets halted also clears active.
// R5 - Buffer error bit 5 set on receive overrun or transmit underrun.
// R6 - Receive overrun forces a bus timeout to kill the transaction.
// R7 - Buffer error, no-response and missed-frame bits stay set once set.
// R8 - Babble sets bit 4 and also halts the descriptor.
// R9 - No valid device response sets no-response error bit 3.
// R10 - Periodic full/low speed: missed complete-split sets bit 2.
// R11 - Full/low speed: bit 1 picks start-split (0) or complete-split (1).
// R12 - High speed OUT: bit 0 picks OUT (0) or PING (1).
// R13 - Not high speed: bit 0 set when periodic split gets ERR handshake.
// R14 - Software gives page aligned pointers; low bits reserved except first.
// R15 - Current page index selects the starting buffer pointer.
// R16 - Crossing a 4K boundary advances page index and next pointer.
// R17 - First pointer low 12 bits are the offset; others ignored.
// R18 - Link bits 31:5 give next object address; never a transfer descriptor.
// R19 - Link bits 2:1 select isochronous, queue head, split iso or span node.
// R20 - Software writes zeros into link bits 4:3.
// R21 - Periodic queue head: link bit 0 marks end of periodic list.
// R22 - Asynchronous queue head: terminate bit ignored; software keeps links valid.
// R23 - Failed transaction decrements two-bit counter; one to zero halts.
// R24 - Inactive descriptor issues nothing and follows the horizontal link.
package udsl_pkg;
   localparam logic [5:0] OFF_TOKEN = 6'h00;
   localparam logic [5:0] OFF_BUF0  = 6'h04;
   localparam logic [5:0] OFF_LINK  = 6'h18;
   localparam logic [5:0] OFF_CTRL  = 6'h1C;
   localparam logic [5:0] OFF_ADDR  = 6'h20;
   localparam logic [5:0] OFF_NEXT  = 6'h24;
   localparam int ST_ACTIVE = 7;
   localparam int ST_HALT   = 6;
   localparam int ST_BUFERR = 5;
   localparam int ST_BABBLE = 4;
   localparam int ST_NORESP = 3;
   localparam int ST_MISSED = 2;
   localparam int ST_SPLIT  = 1;
   localparam int ST_PING   = 0;
   localparam int TOK_CONSECUTIVE_FAULT_COUNTER_LO  = 10;
   localparam int TOK_CPAGE_LO = 12;
   localparam int PAGE_BITS    = 12;
   localparam int LINK_ADDR_LO = 5;
   localparam int LINK_TYP_LO  = 1;
   localparam int CTRL_TOK_LO  = 2;
   localparam int CTRL_PER     = 4;
   localparam int NUM_PTR      = 5;
   localparam logic [1:0] CONSECUTIVE_FAULT_COUNTER_MAX  = 2'h3;
   localparam logic [1:0] SPD_HS    = 2'h2;
   localparam logic [1:0] TOK_OUT   = 2'h0;
   localparam logic [1:0] TOK_IN    = 2'h1;
   localparam logic [7:0] ST_RST    = 8'h00;
   typedef enum logic [1:0] {
      UDSL_OBJ_ISO   = 2'b00,
      UDSL_OBJ_QH    = 2'b01,
      UDSL_OBJ_SPISO = 2'b10,
      UDSL_OBJ_SPAN  = 2'b11
   } udsl_obj_e;
   typedef enum logic [2:0] {
      UDSL_K_OUT    = 3'b000,
      UDSL_K_PING   = 3'b001,
      UDSL_K_SSPLIT = 3'b010,
      UDSL_K_CSPLIT = 3'b011,
      UDSL_K_IN     = 3'b100,
      UDSL_K_SETUP  = 3'b101,
      UDSL_K_NONE   = 3'b111
   } udsl_kind_e;
endpackage

// ---- hdl/udsl_status_upd.sv ----
`timescale 1ns/1ps
module udsl_status_upd
   import udsl_pkg::*;
(
   input  wire logic [7:0] status_i,
   input  wire logic [1:0] consecutive_fault_counter_i,
   input  wire logic       hs_i,
   input  wire logic       hs_out_i,
   input  wire logic       periodic_i,
   input  wire logic       babble_i,
   input  wire logic       stall_i,
   input  wire logic       noresp_i,
   input  wire logic       overrun_i,
   input  wire logic       underrun_i,
   input  wire logic       missed_i,
   input  wire logic       errhs_i,
   input  wire logic       ping_i,
   output logic      [7:0] status_o,
   output logic      [1:0] consecutive_fault_counter_o,
   output logic            halt_o
);
   wire ok      = !(babble_i | stall_i | noresp_i | overrun_i | underrun_i);
   wire to_zero = noresp_i && (consecutive_fault_counter_i == 2'h1); // R23
   assign halt_o = babble_i | stall_i | to_zero; // R3 R8
   assign status_o[ST_ACTIVE] = status_i[ST_ACTIVE] & ~halt_o; // R4
   assign status_o[ST_HALT]   = status_i[ST_HALT] | halt_o; // R3
   assign status_o[ST_BUFERR] = status_i[ST_BUFERR] | overrun_i | underrun_i; // R5 R7
   assign status_o[ST_BABBLE] = status_i[ST_BABBLE] | babble_i; // R8
   assign status_o[ST_NORESP] = status_i[ST_NORESP] | noresp_i; // R9 R7
   assign status_o[ST_MISSED] = status_i[ST_MISSED] | (missed_i & ~hs_i & periodic_i); // R10 R7
   assign status_o[ST_SPLIT]  = (!hs_i && ok) ? ~status_i[ST_SPLIT] : status_i[ST_SPLIT]; // R11
   assign status_o[ST_PING]   = hs_out_i ? ping_i : // R12
      (status_i[ST_PING] | (~hs_i & periodic_i & errhs_i)); // R13
   assign consecutive_fault_counter_o = (noresp_i && consecutive_fault_counter_i != 2'h0) ? consecutive_fault_counter_i - 2'h1 : // R23
      ((ok && consecutive_fault_counter_i != 2'h0) ? CONSECUTIVE_FAULT_COUNTER_MAX : consecutive_fault_counter_i);
endmodule // udsl_status_upd

// ---- hdl/udsl_page_walk.sv ----
`timescale 1ns/1ps
module udsl_page_walk
   import udsl_pkg::*;
#(
   parameter int N_PTR = NUM_PTR
)(
   input  wire logic [32*N_PTR-1:0] ptr_i,
   input  wire logic [2:0]          cpage_i,
   input  wire logic [11:0]         off_i,
   input  wire logic [12:0]         bytes_i,
   output logic      [31:0]         addr_o,
   output logic      [31:0]         next_base_o,
   output logic                     cross_o,
   output logic      [2:0]          cpage_o,
   output logic      [11:0]         off_o
);
   if (N_PTR < 1 || N_PTR > 8) begin : g_chk
      $error("udsl_page_walk: page index reaches at most eight pointers");
   end
   function automatic logic [19:0] page_of(input logic [32*N_PTR-1:0] p, input logic [2:0] i);
      page_of = (i < N_PTR) ? p[32*i+PAGE_BITS +: 20] : 20'h00000;
   endfunction
   wire [13:0] sum = {2'h0, off_i} + {1'b0, bytes_i};
   assign addr_o      = {page_of(ptr_i, cpage_i), off_i}; // R15 R17
   assign next_base_o = {page_of(ptr_i, cpage_i + 3'h1), 12'h000}; // R16
   assign cross_o     = sum[13:12] != 2'h0; // R16
   assign cpage_o     = cpage_i + {1'b0, sum[13:12]}; // R16
   assign off_o       = sum[11:0];
endmodule // udsl_page_walk

// ---- hdl/udsl_link_engine.sv ----
`timescale 1ns/1ps
module udsl_link_engine
   import udsl_pkg::*;
#(
   parameter int N_PTR = NUM_PTR
)(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [5:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        done_i,
   input  wire logic [12:0] bytes_i,
   input  wire logic        babble_i,
   input  wire logic        stall_i,
   input  wire logic        noresp_i,
   input  wire logic        overrun_i,
   input  wire logic        underrun_i,
   input  wire logic        missed_i,
   input  wire logic        errhs_i,
   input  wire logic        ping_i,
   output logic             force_timeout_o,
   output logic             txn_allowed_o,
   output udsl_pkg::udsl_kind_e txn_kind_o,
   output logic      [31:0] buf_addr_o,
   output logic      [31:0] buf_next_o,
   output logic             page_cross_o,
   output logic             follow_link_o,
   output logic      [31:0] next_obj_addr_o,
   output udsl_pkg::udsl_obj_e next_obj_type_o,
   output logic             list_end_o
);
   import udsl_pkg::*;

   if (N_PTR != NUM_PTR) begin : g_chk
      $error("udsl_link_engine: pointer list must hold five entries");
   end

   // ------------------------------------------------------------
   // Descriptor state
   // ------------------------------------------------------------
   logic [7:0]  status_r;
   logic [1:0]  consecutive_fault_counter_r;
   logic [2:0]  cpage_r;
   logic [11:0] off_r;
   logic [31:0] ptr_r [N_PTR];
   logic [31:0] link_r;
   logic [4:0]  ctrl_r;
   logic [31:0] rdata_r;
   logic        tmo_r;
   udsl_kind_e  kind_r;
   logic [31:0] addr_r;
   logic [31:0] bnext_r;
   logic        cross_r;
   logic        follow_r;
   logic [31:0] nobj_r;
   udsl_obj_e   ntyp_r;
   logic        lend_r;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire        hs       = ctrl_r[1:0] == SPD_HS;
   wire [1:0]  tok      = ctrl_r[CTRL_TOK_LO +: 2];
   wire        periodic = ctrl_r[CTRL_PER];
   wire        hs_out   = hs && (tok == TOK_OUT);
   wire        active   = status_r[ST_ACTIVE];
   wire        upd      = done_i && active; // R24
   wire        wr_tok   = wr_i && addr_i == OFF_TOKEN;
   wire        wr_link  = wr_i && addr_i == OFF_LINK;
   wire        wr_ctrl  = wr_i && addr_i == OFF_CTRL;
   wire        wr_ptr   = wr_i && addr_i >= OFF_BUF0 && addr_i < OFF_LINK && addr_i[1:0] == 2'h0;
   wire [2:0]  ptr_idx  = 3'(addr_i[4:2] - 3'h1);
   wire [7:0]  st_nxt;
   wire [1:0]  consecutive_fault_counter_nxt;
   wire        halt_now;
   wire [31:0] addr_nxt;
   wire [31:0] bnext_nxt;
   wire        cross_nxt;
   wire [2:0]  cpage_nxt;
   wire [11:0] off_nxt;
   wire [32*N_PTR-1:0] ptr_flat;
   wire [31:0] tok_word = {17'h0, cpage_r, consecutive_fault_counter_r, 2'h0, status_r};

   for (genvar g = 0; g < N_PTR; g++) begin : g_flat
      assign ptr_flat[32*g +: 32] = ptr_r[g];
   end

   udsl_status_upd u_stat (
      .status_i   (status_r),
      .consecutive_fault_counter_i     (consecutive_fault_counter_r),
      .hs_i       (hs),
      .hs_out_i   (hs_out),
      .periodic_i (periodic),
      .babble_i   (babble_i),
      .stall_i    (stall_i),
      .noresp_i   (noresp_i),
      .overrun_i  (overrun_i),
      .underrun_i (underrun_i),
      .missed_i   (missed_i),
      .errhs_i    (errhs_i),
      .ping_i     (ping_i),
      .status_o   (st_nxt),
      .consecutive_fault_counter_o     (consecutive_fault_counter_nxt),
      .halt_o     (halt_now)
   );

   udsl_page_walk #(.N_PTR(N_PTR)) u_page (
      .ptr_i       (ptr_flat),
      .cpage_i     (cpage_r),
      .off_i       (off_r),
      .bytes_i     (bytes_i),
      .addr_o      (addr_nxt),
      .next_base_o (bnext_nxt),
      .cross_o     (cross_nxt),
      .cpage_o     (cpage_nxt),
      .off_o       (off_nxt)
   );

   wire [2:0] kind_sel =
      !active || status_r[ST_HALT] ? UDSL_K_NONE :
      !hs                          ? (status_r[ST_SPLIT] ? UDSL_K_CSPLIT : UDSL_K_SSPLIT) : // R11
      hs_out                       ? (status_r[ST_PING] ? UDSL_K_PING : UDSL_K_OUT) : // R12
      tok == TOK_IN                ? UDSL_K_IN : UDSL_K_SETUP;
   wire       lend_nxt = periodic && link_r[0]; // R21 R22

   wire wr_ptr_rd = addr_i >= OFF_BUF0 && addr_i < OFF_LINK && addr_i[1:0] == 2'h0;
   wire [31:0] rd_mux =
      addr_i == OFF_TOKEN ? tok_word :
      wr_ptr_rd         ? ptr_r[ptr_idx] :
      addr_i == OFF_LINK  ? link_r :
      addr_i == OFF_CTRL  ? {27'h0, ctrl_r} :
      addr_i == OFF_ADDR  ? addr_r :
      addr_i == OFF_NEXT  ? {nobj_r[31:5], 1'b0, lend_r, ntyp_r, follow_r} :
      32'h0000_0000;

   // ------------------------------------------------------------
   // Status, counter and page state
   // ------------------------------------------------------------
   // Hardware update wins over a same-cycle software token write
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status_r <= ST_RST;
         consecutive_fault_counter_r   <= 2'h0;
         cpage_r  <= 3'h0;
         off_r    <= 12'h000;
      end else if (upd) begin
         status_r <= st_nxt; // R1
         consecutive_fault_counter_r   <= consecutive_fault_counter_nxt; // R23
         cpage_r  <= cpage_nxt; // R16
         off_r    <= off_nxt;
      end else begin
         if (wr_tok) begin
            status_r <= wdata_i[7:0];
            consecutive_fault_counter_r   <= wdata_i[TOK_CONSECUTIVE_FAULT_COUNTER_LO +: 2];
            cpage_r  <= wdata_i[TOK_CPAGE_LO +: 3];
         end
         if (wr_ptr && ptr_idx == 3'h0) begin
            off_r <= wdata_i[11:0]; // R17
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < N_PTR; i++) begin
            ptr_r[i] <= 32'h0000_0000;
         end
         link_r <= 32'h0000_0001;
         ctrl_r <= 5'h00;
      end else begin
         if (wr_ptr) begin
            ptr_r[ptr_idx] <= wdata_i;
         end
         if (wr_link) begin
            link_r <= wdata_i;
         end
         if (wr_ctrl) begin
            ctrl_r <= wdata_i[4:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r  <= 32'h0000_0000;
         tmo_r    <= 1'b0;
         kind_r   <= UDSL_K_NONE;
         addr_r   <= 32'h0000_0000;
         bnext_r  <= 32'h0000_0000;
         cross_r  <= 1'b0;
         follow_r <= 1'b0;
         nobj_r   <= 32'h0000_0000;
         ntyp_r   <= UDSL_OBJ_ISO;
         lend_r   <= 1'b0;
      end else begin
         rdata_r  <= rd_i ? rd_mux : 32'h0000_0000;
         tmo_r    <= upd && overrun_i; // R6
         kind_r   <= udsl_kind_e'(kind_sel);
         addr_r   <= addr_nxt; // R15
         bnext_r  <= bnext_nxt;
         cross_r  <= upd && cross_nxt; // R16
         follow_r <= !active; // R24
         nobj_r   <= {link_r[31:LINK_ADDR_LO], 5'h00}; // R18
         ntyp_r   <= udsl_obj_e'(link_r[LINK_TYP_LO +: 2]); // R19
         lend_r   <= lend_nxt; // R21
      end
   end

   assign rdata_o         = rdata_r;
   assign force_timeout_o = tmo_r;
   assign txn_allowed_o   = kind_r != UDSL_K_NONE;
   assign txn_kind_o      = kind_r;
   assign buf_addr_o      = addr_r;
   assign buf_next_o      = bnext_r;
   assign page_cross_o    = cross_r;
   assign follow_link_o   = follow_r;
   assign next_obj_addr_o = nobj_r;
   assign next_obj_type_o = ntyp_r;
   assign list_end_o      = lend_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_halt_clears_act: assert property ( // R4
      upd && halt_now |=> status_r[ST_HALT] && !status_r[ST_ACTIVE])
      else $error("halt did not clear active");

   a_halt_cause: assert property ( // R3
      upd && (stall_i || babble_i) |=> status_r[ST_HALT])
      else $error("stall or babble did not halt");

   a_babble_flag: assert property ( // R8
      upd && babble_i |=> status_r[ST_BABBLE] && status_r[ST_HALT])
      else $error("babble flag missing");

   a_buferr_sticky: assert property ( // R7
      status_r[ST_BUFERR] && !wr_tok |=> status_r[ST_BUFERR])
      else $error("buffer error flag dropped");

   a_noresp_set: assert property ( // R9
      upd && noresp_i |=> status_r[ST_NORESP])
      else $error("no-response flag missing");

   a_overrun_tmo: assert property ( // R6
      upd && overrun_i |=> force_timeout_o ##1 force_timeout_o == $past(upd && overrun_i))
      else $error("overrun timeout missing");

   a_buferr_set: assert property ( // R5
      upd && (overrun_i || underrun_i) |=> status_r[ST_BUFERR])
      else $error("buffer error not set");

   a_consecutive_fault_counter_zero: assert property ( // R23
      upd && noresp_i && consecutive_fault_counter_r == 2'h1 |=> consecutive_fault_counter_r == 2'h0 && status_r[ST_HALT] ##1
      txn_kind_o == UDSL_K_NONE)
      else $error("counter zero did not halt");

   a_consecutive_fault_counter_dec: assert property ( // R23
      upd && noresp_i && consecutive_fault_counter_r == 2'h3 |=> consecutive_fault_counter_r == 2'h2)
      else $error("counter not decremented");

   a_page_cross: assert property ( // R16
      upd && cross_nxt |=> cpage_r == $past(cpage_r) + 3'h1 && page_cross_o)
      else $error("page index not advanced");

   a_ping_kind: assert property ( // R12
      active && !status_r[ST_HALT] && hs_out && status_r[ST_PING] && !upd && !wr_tok
      && !wr_ctrl |=> txn_kind_o == UDSL_K_PING)
      else $error("ping not issued");

   a_link_decode: assert property ( // R19
      ##1 $stable(link_r) |=> next_obj_type_o == udsl_obj_e'($past(link_r[2:1], 2)))
      else $error("link type decode wrong");

   a_list_end: assert property ( // R21
      periodic && link_r[0] |=> list_end_o)
      else $error("periodic end not flagged");

   a_inactive_idle: assert property ( // R24
      arst_n_i && !active |=> !txn_allowed_o && follow_link_o)
      else $error("inactive descriptor issued");

   c_halt_seen:  cover property (upd && halt_now);
   c_page_cross: cover property (upd && cross_nxt);
   c_split_flip: cover property (upd && !hs ##2 txn_kind_o == UDSL_K_CSPLIT);
   c_overrun:    cover property (upd && overrun_i ##1 force_timeout_o);
endmodule // udsl_link_engine

// ---- testbench/udsl_host_model.sv ----
`timescale 1ns/1ps
module udsl_host_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] rdata_i,
   output logic      [5:0]  addr_o,
   output logic      [31:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic             done_o,
   output logic      [12:0] bytes_o,
   output logic      [7:0]  flags_o
);
   import udsl_pkg::*;
   initial begin
      {addr_o, wdata_o, wr_o, rd_o, done_o, bytes_o, flags_o} = '0;
   end
   // ---------------------------------------------
   // Bus cycles
   // ---------------------------------------------
   task automatic wr_word(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
   endtask
   task automatic rd_word(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      #1 d = rdata_i;
   endtask
   // Flags: babble stall noresp overrun underrun missed errhs ping
   task automatic txn(input logic [7:0] f, input logic [12:0] b);
      @(posedge clk_i);
      done_o  <= 1'b1;
      flags_o <= f;
      bytes_o <= b;
      @(posedge clk_i);
      done_o  <= 1'b0;
      flags_o <= 8'h00;
   endtask
   // ---------------------------------------------
   // Descriptor building
   // ---------------------------------------------
   task automatic put_token(input logic [7:0] st, input logic [1:0] ce, input logic [2:0] cp);
      wr_word(OFF_TOKEN, {17'h00000, cp, ce, 2'h0, st});
   endtask
   task automatic put_buf(input int i, input logic [19:0] pg, input logic [11:0] off);
      wr_word(OFF_BUF0 + 6'(4 * i), {pg, (i == 0) ? off : 12'h000});
   endtask
   task automatic put_link(input logic [26:0] a, input logic [1:0] t, input logic term);
      wr_word(OFF_LINK, {a, 2'b00, t, term});
   endtask
endmodule // udsl_host_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
   import udsl_pkg::*;
   logic        clk_i;
   logic        arst_n_i;
   logic [5:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        done;
   logic [12:0] bytes;
   logic [7:0]  flags;
   logic        force_timeout;
   logic        txn_allowed;
   udsl_kind_e  kind;
   logic [31:0] buf_addr;
   logic [31:0] buf_next;
   logic        page_cross;
   logic        follow_link;
   logic [31:0] next_addr;
   udsl_obj_e   next_type;
   logic        list_end;
   logic [31:0] d;
   logic [55:0] r;
   int          fails;
   int          tests_run;
   // ctrl, status, consecutive_fault_counter, flags, expected status, expected consecutive_fault_counter, expected kind
   localparam logic [55:0] ROWS [14] = '{
      56'h06_80_03_20_88_02_04, 56'h06_80_01_20_48_00_07, 56'h06_80_03_40_40_03_07,
      56'h06_80_03_80_50_03_07, 56'h06_80_03_10_A0_03_04, 56'h02_80_03_08_A0_03_00,
      56'h10_80_02_04_86_03_03, 56'h10_80_03_02_83_03_03, 56'h00_82_03_04_80_03_02,
      56'h02_80_03_01_81_03_01, 56'h06_A8_01_00_A8_03_04, 56'h0A_80_02_00_80_03_05,
      56'h06_00_02_20_00_02_07, 56'h06_80_00_20_88_00_04};
   udsl_link_engine udsl_link_engine_inst (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .done_i(done), .bytes_i(bytes), .babble_i(flags[7]),
      .stall_i(flags[6]), .noresp_i(flags[5]), .overrun_i(flags[4]),
      .underrun_i(flags[3]), .missed_i(flags[2]), .errhs_i(flags[1]), .ping_i(flags[0]),
      .force_timeout_o(force_timeout), .txn_allowed_o(txn_allowed), .txn_kind_o(kind),
      .buf_addr_o(buf_addr), .buf_next_o(buf_next), .page_cross_o(page_cross),
      .follow_link_o(follow_link), .next_obj_addr_o(next_addr),
      .next_obj_type_o(next_type), .list_end_o(list_end));
   udsl_host_model udsl_host_model_inst (
      .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd), .done_o(done), .bytes_o(bytes), .flags_o(flags));
   // ---------------------------------------------
   // Checking and closing
   // ---------------------------------------------
   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", n, e, g);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      complete_run;
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      fails = 0;
      tests_run = 0;
      arst_n_i = 1'b0;
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 chk_word("kind", {29'h0, UDSL_K_NONE}, {29'h0, kind});
      chk_bit("allowed", 1'b0, txn_allowed);
      udsl_host_model_inst.rd_word(OFF_LINK, d);
      chk_word("link reset", 32'h0000_0001, d);
      udsl_host_model_inst.rd_word(6'h3C, d);
      chk_word("unmapped", 32'h0000_0000, d);
      $display("test reset done");
      for (int i = 0; i < 14; i++) begin
         r = ROWS[i];
         udsl_host_model_inst.wr_word(OFF_CTRL, {24'h0, r[55:48]});
         udsl_host_model_inst.put_token(r[47:40], r[33:32], 3'h0);
         udsl_host_model_inst.txn(r[31:24], 13'h0000);
         #1 chk_bit("force_timeout", r[28] & r[47], force_timeout);
         udsl_host_model_inst.rd_word(OFF_TOKEN, d);
         chk_word("status", {24'h0, r[23:16]}, {24'h0, d[7:0]});
         chk_word("consecutive_fault_counter", {30'h0, r[9:8]}, {30'h0, d[11:10]});
         chk_word("kind", {29'h0, r[2:0]}, {29'h0, kind});
         chk_bit("follow_link", ~r[23], follow_link);
         chk_bit("allowed", r[2:0] != 3'h7, txn_allowed);
      end
      $display("test outcome rows done");
      // Reserved low bits of a later pointer deliberately nonzero
      udsl_host_model_inst.wr_word(OFF_CTRL, 32'h0000_0006);
      udsl_host_model_inst.put_buf(0, 20'h00010, 12'hF00);
      udsl_host_model_inst.wr_word(OFF_BUF0 + 6'h04, 32'h0002_0ABC);
      udsl_host_model_inst.put_buf(3, 20'h00040, 12'h000);
      udsl_host_model_inst.put_token(8'h80, 2'h3, 3'h0);
      settle;
      chk_word("buf_addr", 32'h0001_0F00, buf_addr);
      chk_word("buf_next", 32'h0002_0000, buf_next);
      udsl_host_model_inst.rd_word(OFF_BUF0 + 6'h04, d);
      chk_word("buf1 reg", 32'h0002_0ABC, d);
      udsl_host_model_inst.txn(8'h00, 13'h0200);
      #1 chk_bit("page_cross", 1'b1, page_cross);
      settle;
      chk_word("buf_addr", 32'h0002_0100, buf_addr);
      udsl_host_model_inst.put_token(8'h80, 2'h3, 3'h3);
      settle;
      chk_word("buf_addr", 32'h0004_0100, buf_addr);
      udsl_host_model_inst.rd_word(OFF_ADDR, d);
      chk_word("addr reg", 32'h0004_0100, d);
      $display("test page walk done");
      for (int t = 0; t < 4; t++) begin
         udsl_host_model_inst.wr_word(OFF_CTRL, {27'h0, t[0], 4'h6});
         udsl_host_model_inst.put_link(27'h0123456, t[1:0], 1'b1);
         settle;
         chk_word("next_addr", 32'h0246_8AC0, next_addr);
         chk_word("next_type", {30'h0, t[1:0]}, {30'h0, next_type});
         chk_bit("list_end", t[0], list_end);
         udsl_host_model_inst.rd_word(OFF_NEXT, d);
         chk_word("next reg", {27'h0123456, 1'b0, t[0], t[1:0], 1'b0}, d);
      end
      $display("test link done");
      // Token write in the cycle of a hardware update is dropped
      fork
         udsl_host_model_inst.put_token(8'h00, 2'h3, 3'h0);
         udsl_host_model_inst.txn(8'h10, 13'h0000);
      join
      #1 chk_bit("force_timeout", 1'b1, force_timeout);
      udsl_host_model_inst.rd_word(OFF_TOKEN, d);
      chk_word("status", 32'h0000_00A0, {24'h0, d[7:0]});
      chk_word("consecutive_fault_counter", 32'h0000_0003, {30'h0, d[11:10]});
      $display("test set wins done");
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      #1 chk_word("kind", {29'h0, UDSL_K_NONE}, {29'h0, kind});
      chk_bit("list_end", 1'b0, list_end);
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      settle;
      chk_bit("follow_link", 1'b1, follow_link);
      chk_bit("allowed", 1'b0, txn_allowed);
      udsl_host_model_inst.rd_word(OFF_TOKEN, d);
      chk_word("token reset", 32'h0000_0000, d);
      udsl_host_model_inst.rd_word(OFF_LINK, d);
      chk_word("link reset", 32'h0000_0001, d);
      $display("test reset again done");
      complete_run;
   end
endmodule // tb
